/* verilog/output_terminal_pkg.sv */
package output_terminal_pkg;

    // Number of discrete outputs: open collector 1, open collector 2, relay.
    localparam int NUM_OUTPUTS = 3;
    localparam int IDX_OUT1    = 0;
    localparam int IDX_OUT2    = 1;
    localparam int IDX_RELAY   = 2;

    // Function selector codes.
    localparam logic [7:0] FUNC_RUN           = 8'h00;
    localparam logic [7:0] FUNC_FREQ_CONST    = 8'h01;
    localparam logic [7:0] FUNC_FREQ_ABOVE    = 8'h02;
    localparam logic [7:0] FUNC_OVERLOAD      = 8'h03;
    localparam logic [7:0] FUNC_PID_DEV       = 8'h04;
    localparam logic [7:0] FUNC_ALARM         = 8'h05;
    localparam logic [7:0] FUNC_FREQ_CROSS    = 8'h06;
    localparam logic [7:0] FUNC_TORQUE_THRESH = 8'h07;
    localparam logic [7:0] FUNC_SUPPLY_LOW    = 8'h09;
    localparam logic [7:0] FUNC_TORQUE_LIMIT  = 8'h0A;
    localparam logic [7:0] FUNC_RUN_HOURS     = 8'h0B;
    localparam logic [7:0] FUNC_POWER_HOURS   = 8'h0C;
    localparam logic [7:0] FUNC_THERMAL       = 8'h0D;
    localparam logic [7:0] FUNC_BRAKE_RELEASE = 8'h13;
    localparam logic [7:0] FUNC_BRAKE_FAULT   = 8'h14;

    // Default function selections.
    localparam logic [7:0] OUT1_FUNC_DEFAULT  = FUNC_RUN;
    localparam logic [7:0] OUT2_FUNC_DEFAULT  = FUNC_FREQ_CONST;
    localparam logic [7:0] RELAY_FUNC_DEFAULT = FUNC_ALARM;

    // Polarity selection codes and defaults.
    localparam logic [7:0] POL_NORMALLY_OPEN    = 8'h00;
    localparam logic [7:0] POL_NORMALLY_CLOSED  = 8'h01;
    localparam logic [7:0] OUT1_POL_DEFAULT     = POL_NORMALLY_OPEN;
    localparam logic [7:0] OUT2_POL_DEFAULT     = POL_NORMALLY_OPEN;
    localparam logic [7:0] RELAY_POL_DEFAULT    = POL_NORMALLY_CLOSED;

    // Delays are in tenths of a second, 0.0 to 100.0 s.
    localparam int         DELAY_WIDTH       = 10;
    localparam logic [9:0] DELAY_MAX_TENTHS  = 10'h3E8;
    localparam logic [9:0] DELAY_DEFAULT     = 10'h000;

    // Timing base.
    localparam int CLOCK_HZ         = 25000000;
    localparam int TICK_MS          = 100;
    localparam int TICK_CYCLES      = CLOCK_HZ / 1000 * TICK_MS;
    localparam int RESET_HOLD_MS    = 1000;
    localparam int RESET_HOLD_TICKS = RESET_HOLD_MS / TICK_MS;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_TIMING = 3'b010,
        ST_HOLD   = 3'b100
    } delay_state_type;

endpackage

/* verilog/output_terminal_conditioner.sv */
`timescale 1ns/10ps
// What this block does
// - Open-collector outputs default normally open, invertible.
// - Relay polarity selectable, defaults normally closed.
// - Per-output ON delay, zero to 100 s.
// - Per-output OFF delay, default zero.
// - Reset input drops undelayed outputs immediately.
// - Delayed-off output holds one second after reset.
// - Code 00 follows run mode.
// - Code 01 follows constant-speed arrival.
// - Code 02 follows at-or-above set frequency.
// - Code 03 follows overload notice.
// - Code 04 follows PID deviation.
// - Code 05 follows latched alarm.
// - Code 06 follows set-frequency crossing.
// - Code 07 follows torque threshold.
// - Code 09 follows undervoltage.
// - Code 10 follows torque limiting.
// - Code 11 follows run time expiry.
// - Code 12 follows power-on time expiry.
// - Code 13 follows thermal warning.
// - Code 19 follows brake release.
// - Code 20 follows brake fault.
// - Per-output function selector with documented defaults.
module output_terminal_conditioner
    import output_terminal_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        run_mode,
    input  wire logic        freq_reached_const,
    input  wire logic        freq_at_or_above,
    input  wire logic        freq_crossing_pulse,
    input  wire logic        overload_notice_flag,
    input  wire logic        pid_deviation_flag,
    input  wire logic        fault_latched_flag,
    input  wire logic        torque_threshold_flag,
    input  wire logic        supply_low_flag,
    input  wire logic        torque_limiting_flag,
    input  wire logic        run_hours_expired,
    input  wire logic        power_hours_expired,
    input  wire logic        thermal_warning,
    input  wire logic        brake_release,
    input  wire logic        brake_fault,
    input  wire logic        reset_input,
    input  wire logic        config_load,
    input  wire logic [7:0]  out1_function_sel,
    input  wire logic [7:0]  out2_function_sel,
    input  wire logic [7:0]  relay_function_sel,
    input  wire logic [7:0]  out1_polarity_sel,
    input  wire logic [7:0]  out2_polarity_sel,
    input  wire logic [7:0]  relay_polarity_sel,
    input  wire logic [9:0]  out1_on_delay,
    input  wire logic [9:0]  out2_on_delay,
    input  wire logic [9:0]  relay_on_delay,
    input  wire logic [9:0]  out1_off_delay,
    input  wire logic [9:0]  out2_off_delay,
    input  wire logic [9:0]  relay_off_delay,
    output logic             out1_terminal,
    output logic             out2_terminal,
    output logic             relay_terminal,
    output logic [2:0]       logical_state
);

    // Configuration is captured on config_load so that a setting changed
    // mid-run cannot glitch an output between two partial values.
    logic [7:0] func_reg  [NUM_OUTPUTS];
    logic [7:0] func_next [NUM_OUTPUTS];
    logic [7:0] pol_reg   [NUM_OUTPUTS];
    logic [7:0] pol_next  [NUM_OUTPUTS];
    logic [9:0] on_reg    [NUM_OUTPUTS];
    logic [9:0] on_next   [NUM_OUTPUTS];
    logic [9:0] off_reg   [NUM_OUTPUTS];
    logic [9:0] off_next  [NUM_OUTPUTS];

    logic [7:0] func_in [NUM_OUTPUTS];
    logic [7:0] pol_in  [NUM_OUTPUTS];
    logic [9:0] on_in   [NUM_OUTPUTS];
    logic [9:0] off_in  [NUM_OUTPUTS];

    assign func_in[IDX_OUT1]  = out1_function_sel;
    assign func_in[IDX_OUT2]  = out2_function_sel;
    assign func_in[IDX_RELAY] = relay_function_sel;
    assign pol_in[IDX_OUT1]   = out1_polarity_sel;
    assign pol_in[IDX_OUT2]   = out2_polarity_sel;
    assign pol_in[IDX_RELAY]  = relay_polarity_sel;
    assign on_in[IDX_OUT1]    = out1_on_delay;
    assign on_in[IDX_OUT2]    = out2_on_delay;
    assign on_in[IDX_RELAY]   = relay_on_delay;
    assign off_in[IDX_OUT1]   = out1_off_delay;
    assign off_in[IDX_OUT2]   = out2_off_delay;
    assign off_in[IDX_RELAY]  = relay_off_delay;

    // One prescaler serves all three outputs; the price is that each delay
    // may come up to one tick short, depending on where the count stood.
    logic [31:0] prescale_reg;
    logic [31:0] prescale_next;
    logic        tick;

    always_comb begin
        tick = (prescale_reg == 32'(TICK_CYCLES_P - 1));
        if (tick) begin
            prescale_next = 32'h00000000;
        end else begin
            prescale_next = prescale_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_reg <= 32'h00000000;
        end else begin
            prescale_reg <= prescale_next;
        end
    end

    logic [NUM_OUTPUTS-1:0] term_out;

    genvar g;
    generate
        for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
            localparam logic [7:0] FDEF = (g == IDX_OUT1) ? OUT1_FUNC_DEFAULT :
                (g == IDX_OUT2) ? OUT2_FUNC_DEFAULT : RELAY_FUNC_DEFAULT;
            localparam logic [7:0] PDEF = (g == IDX_OUT1) ? OUT1_POL_DEFAULT :
                (g == IDX_OUT2) ? OUT2_POL_DEFAULT : RELAY_POL_DEFAULT;

            delay_state_type state_reg;
            delay_state_type state_next;
            logic [9:0]      count_reg;
            logic [9:0]      count_next;
            logic            active_reg;
            logic            active_next;
            logic            cond;
            logic [9:0]      on_lim;
            logic [9:0]      off_lim;
            logic [9:0]      step_lim;
            logic            term_next;

            always_comb begin
                if (config_load) begin
                    func_next[g] = func_in[g];
                    pol_next[g]  = pol_in[g];
                    on_next[g]   = on_in[g];
                    off_next[g]  = off_in[g];
                end else begin
                    func_next[g] = func_reg[g];
                    pol_next[g]  = pol_reg[g];
                    on_next[g]   = on_reg[g];
                    off_next[g]  = off_reg[g];
                end
            end

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    func_reg[g] <= FDEF;
                    pol_reg[g]  <= PDEF;
                    on_reg[g]   <= DELAY_DEFAULT;
                    off_reg[g]  <= DELAY_DEFAULT;
                end else begin
                    func_reg[g] <= func_next[g];
                    pol_reg[g]  <= pol_next[g];
                    on_reg[g]   <= on_next[g];
                    off_reg[g]  <= off_next[g];
                end
            end

            // Settings above the range saturate rather than wrap, so an
            // oversized value can never turn into a short delay.
            always_comb begin
                on_lim  = on_reg[g];
                off_lim = off_reg[g];
                if (on_reg[g] > DELAY_MAX_TENTHS) begin
                    on_lim = DELAY_MAX_TENTHS;
                end
                if (off_reg[g] > DELAY_MAX_TENTHS) begin
                    off_lim = DELAY_MAX_TENTHS;
                end
            end

            // Unlisted codes give an inactive condition, so a stray selector
            // value can never make an output active.
            always_comb begin
                case (func_reg[g])
                    FUNC_RUN:           cond = run_mode;
                    FUNC_FREQ_CONST:    cond = freq_reached_const;
                    FUNC_FREQ_ABOVE:    cond = freq_at_or_above;
                    FUNC_OVERLOAD:      cond = overload_notice_flag;
                    FUNC_PID_DEV:       cond = pid_deviation_flag;
                    FUNC_ALARM:         cond = fault_latched_flag;
                    FUNC_FREQ_CROSS:    cond = freq_crossing_pulse;
                    FUNC_TORQUE_THRESH: cond = torque_threshold_flag;
                    FUNC_SUPPLY_LOW:    cond = supply_low_flag;
                    FUNC_TORQUE_LIMIT:  cond = torque_limiting_flag;
                    FUNC_RUN_HOURS:     cond = run_hours_expired;
                    FUNC_POWER_HOURS:   cond = power_hours_expired;
                    FUNC_THERMAL:       cond = thermal_warning;
                    FUNC_BRAKE_RELEASE: cond = brake_release;
                    FUNC_BRAKE_FAULT:   cond = brake_fault;
                    default:            cond = 1'b0;
                endcase
                // The reset input forces the condition low; the hold state
                // covers the delayed-off case.
                if (reset_input) begin
                    cond = 1'b0;
                end
            end

            // Delay state machine; count_reg holds the ticks still to run.
            always_comb begin
                step_lim    = cond ? on_lim : off_lim;
                state_next  = state_reg;
                count_next  = count_reg;
                active_next = active_reg;
                case (state_reg)
                    ST_IDLE: begin
                        if (cond != active_reg) begin
                            if (reset_input && active_reg &&
                                off_lim != DELAY_DEFAULT) begin
                                state_next = ST_HOLD;
                                count_next = 10'(RESET_HOLD_TICKS);
                            end else if (reset_input) begin
                                active_next = 1'b0;
                            end else if (step_lim == DELAY_DEFAULT) begin
                                // Zero delay passes the change straight on.
                                active_next = cond;
                            end else begin
                                state_next = ST_TIMING;
                                count_next = step_lim;
                            end
                        end
                    end
                    ST_TIMING: begin
                        if (reset_input && active_reg &&
                            off_lim != DELAY_DEFAULT) begin
                            state_next = ST_HOLD;
                            count_next = 10'(RESET_HOLD_TICKS);
                        end else if (reset_input && active_reg) begin
                            // An OFF delay cleared mid-count earns no hold.
                            active_next = 1'b0;
                            state_next  = ST_IDLE;
                        end else if (cond == active_reg) begin
                            // A pulse shorter than the delay dies here.
                            state_next = ST_IDLE;
                        end else if (tick) begin
                            if (count_reg == 10'h001) begin
                                active_next = cond;
                                state_next  = ST_IDLE;
                            end
                            count_next = count_reg - 10'h001;
                        end
                    end
                    ST_HOLD: begin
                        // Tick phase makes the hold about, not exactly, 1 s.
                        if (tick) begin
                            if (count_reg == 10'h001) begin
                                active_next = 1'b0;
                                state_next  = ST_IDLE;
                            end
                            count_next = count_reg - 10'h001;
                        end
                    end
                    default: begin
                        state_next  = ST_IDLE;
                        active_next = 1'b0;
                    end
                endcase
            end

            // Polarity acts after the delay stage, so an inverted terminal
            // keeps exactly the ON and OFF timing of its logical state.
            always_comb begin
                term_next = active_next ^
                    (pol_next[g] == POL_NORMALLY_CLOSED);
            end

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    state_reg   <= ST_IDLE;
                    count_reg   <= 10'h000;
                    active_reg  <= 1'b0;
                    term_out[g] <= (PDEF == POL_NORMALLY_CLOSED);
                end else begin
                    state_reg   <= state_next;
                    count_reg   <= count_next;
                    active_reg  <= active_next;
                    term_out[g] <= term_next;
                end
            end

            assign logical_state[g] = active_reg;
        end
    endgenerate

    assign out1_terminal  = term_out[IDX_OUT1];
    assign out2_terminal  = term_out[IDX_OUT2];
    assign relay_terminal = term_out[IDX_RELAY];

endmodule

/* testbench/terminal_reader.sv */
`timescale 1ns/10ps
// External equipment reading the terminals. With a normally closed
// selection an open contact means the condition is active, so the
// reader undoes the inversion before reporting.
module terminal_reader (
    input  wire logic       clock,
    input  wire logic       out1_terminal,
    input  wire logic       out2_terminal,
    input  wire logic       relay_terminal,
    input  wire logic [2:0] closed_sel,
    output logic [2:0]      energized
);
    always_ff @(posedge clock) begin
        energized <= {relay_terminal, out2_terminal, out1_terminal}
                     ^ closed_sel;
    end
endmodule

/* testbench/output_terminal_chk.sv */
`timescale 1ns/10ps
module output_terminal_chk
    import output_terminal_pkg::*;
#(
    parameter int TICK_CYCLES_P = 4
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       reset_input,
    input  wire logic       config_load,
    input  wire logic [7:0] out1_polarity_sel,
    input  wire logic [7:0] out2_polarity_sel,
    input  wire logic [7:0] relay_polarity_sel,
    input  wire logic [9:0] out1_off_delay,
    input  wire logic [9:0] out2_off_delay,
    input  wire logic [9:0] relay_off_delay,
    input  wire logic       out1_terminal,
    input  wire logic       out2_terminal,
    input  wire logic       relay_terminal,
    input  wire logic [2:0] logical_state
);
    // Margin of a few cycles covers the tick phase at the reset edge.
    localparam int HOLD_LIM = 10 * TICK_CYCLES_P + 3;
    logic [2:0] pol_reg, pol_next, offnz_reg, offnz_next;
    logic [7:0] rs_cnt_reg, rs_cnt_next;
    always_comb begin
        pol_next = pol_reg;
        offnz_next = offnz_reg;
        rs_cnt_next = 8'h00;
        if (config_load) begin
            pol_next = {relay_polarity_sel == 8'h01,
                        out2_polarity_sel == 8'h01,
                        out1_polarity_sel == 8'h01};
            offnz_next = {relay_off_delay != 10'h000,
                          out2_off_delay != 10'h000,
                          out1_off_delay != 10'h000};
        end
        if (reset_input) begin
            rs_cnt_next = (rs_cnt_reg == 8'hFF) ? rs_cnt_reg
                                                : rs_cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pol_reg <= 3'b100;
            offnz_reg <= 3'b000;
            rs_cnt_reg <= 8'h00;
        end else begin
            pol_reg <= pol_next;
            offnz_reg <= offnz_next;
            rs_cnt_reg <= rs_cnt_next;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_cfg_quiet;
        !config_load && !$past(config_load);
    endsequence
    sequence s_held;
        logical_state[0] [*8];
    endsequence
    out1_pol_a: assert property (s_cfg_quiet |->
        out1_terminal == (logical_state[0] ^ pol_reg[0]))
        else $error("out1 terminal polarity wrong");
    out2_pol_a: assert property (s_cfg_quiet |->
        out2_terminal == (logical_state[1] ^ pol_reg[1]))
        else $error("out2 terminal polarity wrong");
    relay_pol_a: assert property (s_cfg_quiet |->
        relay_terminal == (logical_state[2] ^ pol_reg[2]))
        else $error("relay terminal polarity wrong");
    reset_vals_a: assert property ($fell(rst) |->
        logical_state == 3'h0 && relay_terminal && !out1_terminal)
        else $error("outputs not at reset values");
    rs_now_a: assert property (reset_input && offnz_reg == 3'b000
        && !config_load |=> logical_state == 3'h0)
        else $error("reset input did not drop outputs");
    rs_hold_a: assert property ($rose(reset_input) &&
        logical_state[0] && offnz_reg[0] |=> s_held)
        else $error("delayed output dropped early");
    rs_limit_a: assert property (rs_cnt_reg > HOLD_LIM |->
        logical_state == 3'h0)
        else $error("output held too long under reset");
    rs_stay_a: assert property (reset_input && logical_state == 3'h0
        && !config_load |=> logical_state == 3'h0)
        else $error("output turned on under reset");
endmodule
bind output_terminal_conditioner output_terminal_chk #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
) i_output_terminal_chk (
    .clock(clock), .rst(rst), .reset_input(reset_input),
    .config_load(config_load), .out1_polarity_sel(out1_polarity_sel),
    .out2_polarity_sel(out2_polarity_sel),
    .relay_polarity_sel(relay_polarity_sel),
    .out1_off_delay(out1_off_delay), .out2_off_delay(out2_off_delay),
    .relay_off_delay(relay_off_delay), .out1_terminal(out1_terminal),
    .out2_terminal(out2_terminal), .relay_terminal(relay_terminal),
    .logical_state(logical_state)
);

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    import output_terminal_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        reset_input = 1'b0;
    logic        load = 1'b0;
    logic [14:0] cond = 15'h0000;
    logic [7:0]  f1 = 8'h00, f2 = 8'h01, fr = 8'h05;
    logic [7:0]  p1 = 8'h00, p2 = 8'h00, pr = 8'h01;
    logic [9:0]  on1 = 10'h000, off1 = 10'h000, dz = 10'h000;
    logic        o1, o2, orl;
    logic [2:0]  ls, seen;
    int          err_total = 0;
    int          tests_run = 0;
    logic [7:0]  codes [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h14};
    always #20 clock = ~clock;
    output_terminal_conditioner #(
        .TICK_CYCLES_P(4)
    ) i_output_terminal_conditioner (
        .clock(clock), .rst(rst), .run_mode(cond[0]),
        .freq_reached_const(cond[1]), .freq_at_or_above(cond[2]),
        .overload_notice_flag(cond[3]), .pid_deviation_flag(cond[4]),
        .fault_latched_flag(cond[5]), .freq_crossing_pulse(cond[6]),
        .torque_threshold_flag(cond[7]), .supply_low_flag(cond[8]),
        .torque_limiting_flag(cond[9]), .run_hours_expired(cond[10]),
        .power_hours_expired(cond[11]), .thermal_warning(cond[12]),
        .brake_release(cond[13]), .brake_fault(cond[14]),
        .reset_input(reset_input), .config_load(load),
        .out1_function_sel(f1), .out2_function_sel(f2),
        .relay_function_sel(fr), .out1_polarity_sel(p1),
        .out2_polarity_sel(p2), .relay_polarity_sel(pr),
        .out1_on_delay(on1), .out2_on_delay(dz), .relay_on_delay(dz),
        .out1_off_delay(off1), .out2_off_delay(dz), .relay_off_delay(dz),
        .out1_terminal(o1), .out2_terminal(o2), .relay_terminal(orl),
        .logical_state(ls));
    terminal_reader i_terminal_reader (.clock(clock), .out1_terminal(o1),
        .out2_terminal(o2), .relay_terminal(orl), .energized(seen),
        .closed_sel({pr == 8'h01, p2 == 8'h01, p1 == 8'h01}));
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic load_cfg;
        load = 1'b1;
        step(1);
        load = 1'b0;
        step(1);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_codes;
        // Out2 gets an unlisted code, which must never assert.
        for (int i = 0; i < 15; i++) begin
            f1 = codes[i];
            fr = codes[i];
            f2 = 8'h08;
            pr = 8'h00;
            load_cfg();
            cond = 15'h0001 << i;
            step(2);
            chk({ls[1:0], orl}, 3'b011, "code on");
            // Every other condition high: only the selected one counts.
            cond = ~(15'h0001 << i);
            step(2);
            chk({ls[1:0], orl}, 3'b000, "code off");
        end
        cond = 15'h0000;
        {f1, f2, fr, pr} = {8'h00, 8'h01, 8'h05, 8'h01};
        load_cfg();
        chk({orl, o2, o1}, 3'b100, "defaults back");
        $display("test codes done");
    endtask
    task automatic t_polarity;
        {p1, p2, pr} = {8'h01, 8'h01, 8'h00};
        load_cfg();
        step(1);
        chk({orl, o2, o1}, 3'b011, "inverted sense");
        chk(seen, 3'b000, "reader sees idle");
        cond = 15'h0001;
        step(3);
        chk({orl, o2, o1}, 3'b010, "inverted active");
        chk(seen, 3'b001, "reader sees active");
        cond = 15'h0000;
        step(2);
        {p1, p2, pr} = {8'h00, 8'h00, 8'h01};
        load_cfg();
        $display("test polarity done");
    endtask
    task automatic t_delays;
        on1 = 10'h003;
        load_cfg();
        cond = 15'h0001;
        step(6);
        chk(ls, 3'b000, "on delay early");
        step(10);
        chk(ls, 3'b001, "on delay expired");
        off1 = 10'h003;
        load_cfg();
        cond = 15'h0000;
        step(4);
        cond = 15'h0001;
        step(20);
        chk(ls, 3'b001, "short dip filtered");
        cond = 15'h0000;
        step(6);
        chk(ls, 3'b001, "off delay early");
        step(10);
        chk(ls, 3'b000, "off delay expired");
        $display("test delays done");
    endtask
    task automatic t_reset_input;
        on1 = 10'h000;
        load_cfg();
        cond = 15'h0001;
        step(2);
        chk(ls, 3'b001, "active before reset");
        reset_input = 1'b1;
        step(30);
        chk(ls, 3'b001, "held after reset");
        step(16);
        chk(ls, 3'b000, "hold ended");
        reset_input = 1'b0;
        off1 = 10'h000;
        load_cfg();
        step(1);
        chk(ls, 3'b001, "active before drop");
        reset_input = 1'b1;
        step(1);
        chk(ls, 3'b000, "immediate drop");
        reset_input = 1'b0;
        cond = 15'h0000;
        step(2);
        $display("test reset input done");
    endtask
    initial begin
        step(3);
        rst = 1'b0;
        step(1);
        chk({orl, o2, o1}, 3'b100, "reset terminals");
        chk(ls, 3'b000, "reset state");
        t_codes();
        t_polarity();
        t_delays();
        t_reset_input();
        summarize();
    end
    initial begin
        // Tests take well under a thousand cycles.
        #(40 * 5000);
        err_total++;
        summarize();
    end
endmodule
